// *** hw/sar_adc_map.vh ***
`ifndef SAR_ADC_MAP_VH
`define SAR_ADC_MAP_VH
`define RESOLUTION 14
`define NEG_FULL_SCALE_CODE 14'h2000
`define POS_FULL_SCALE_CODE 14'h1FFF
`define MID_CODE 14'h0000
`define CONV_EDGES 5'd18
`define CAL_EDGES_POWERUP 7'd24
`define CAL_EDGES_NORMAL 7'd64
`define STATE_ACQUIRE 2'b00
`define STATE_CONVERT 2'b01
`define STATE_OFFSET_CAL 2'b10
`endif

// *** hw/sar_quantizer.v ***
`timescale 1ns/1ps
`default_nettype none
module sar_quantizer #(
  parameter WIDTH = 14
) (
  input wire signed [WIDTH+1:0] diff_in,
  input wire signed [WIDTH+1:0] ref_in,
  output reg [WIDTH-1:0] code
);
  // Ideal transfer: code = floor(diff * 2^N / (2*ref)), clamped to full scale
  wire signed [2*WIDTH+3:0] scaled;
  wire signed [2*WIDTH+3:0] q;
  wire signed [2*WIDTH+3:0] pos_lim;
  wire signed [2*WIDTH+3:0] neg_lim;
  assign scaled = diff_in <<< (WIDTH - 1);
  assign q = (ref_in == 0) ? 0 :
             ((scaled >= 0) ? scaled / ref_in : ((scaled + 1) / ref_in) - 1);
  assign pos_lim = (1 <<< (WIDTH - 1)) - 1;
  assign neg_lim = -(1 <<< (WIDTH - 1));
  always @* begin
    if (q >= pos_lim) begin
      code = {1'b0, {(WIDTH-1){1'b1}}};
    end else if (q <= neg_lim) begin
      code = {1'b1, {(WIDTH-1){1'b0}}};
    end else begin
      code = q[WIDTH-1:0];
    end
  end
endmodule
`default_nettype wire

// *** hw/sar_adc_serial_frame_control.v ***
// Notes on behaviour
// - After reset the block sits in the acquire state with sampling switches closed.
// - A frame runs from chip select falling to chip select rising.
// - The data pin is not driven while chip select is high.
// - While chip select is low the serial clock steps conversion and shifts data out.
// - Only acquire, convert and offset calibration states exist, steered by the host.
// - Chip select falling in acquire holds the inputs and enters convert.
// - Finishing a calibration, or a conversion outside the power-up frame, returns the block to acquire.
// - The result is a 14-bit two's complement code of the held input difference.
// - Full scale clamps to 2000 and 1FFF hex, and 0 to 1 step gives 0000.
// - One step is twice the reference over two to the fourteenth.
// - Both inputs are held separately and their difference is converted.
// - A leading zero, then MSB-first result on rising edges, then zeros.
// - The first frame after power-up returns all zeros.
// - 24 clocks in the first frame complete calibration, an early rise aborts it.
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_serial_frame_control #(
  parameter WIDTH = `RESOLUTION,
  parameter AW = 16
) (
  input wire mclk,
  input wire rst,
  input wire cs_n,
  input wire sclk,
  input wire signed [AW-1:0] pos_analog_in,
  input wire signed [AW-1:0] neg_analog_in,
  input wire signed [AW-1:0] analog_supply,
  output reg sdo_out,
  output reg sdo_oe,
  output reg sampling_closed,
  output reg [1:0] state,
  output reg cal_done,
  output reg result_valid
);
  // Chip select pin: two sync stages, then the edge detector's memory
  reg cs_meta_reg;
  reg cs_sync_reg;
  reg cs_prev_reg;
  // Serial clock pin: same treatment, it is just another async input
  reg ck_meta_reg;
  reg ck_sync_reg;
  reg ck_prev_reg;
  reg [1:0] state_next;
  // Held samples stand in for the two sampling capacitors
  reg signed [AW-1:0] hold_pos_reg;
  reg signed [AW-1:0] hold_neg_reg;
  // Reference is latched too, so a moving supply cannot skew one conversion
  reg signed [AW-1:0] hold_ref_reg;
  reg [WIDTH-1:0] result_reg;
  reg [WIDTH-1:0] shift_reg;
  reg [6:0] fall_cnt_reg;
  reg first_frame_reg;
  reg short_frame_reg;
  reg frame_invalid_reg;
  wire [WIDTH-1:0] code;
  wire signed [AW+1:0] diff_w;
  wire signed [AW+1:0] ref_w;
  wire cs_fall;
  wire cs_rise;
  wire ck_fall;
  wire ck_rise;
  wire frame_on;
  // Full-width quantizer output, narrowed below
  wire [AW-1:0] quant_full;
  // Reset to the idle level of the pin, so no false edge follows reset
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
    end
  end
  // Serial clock idles low between frames
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ck_meta_reg <= 1'b0;
      ck_sync_reg <= 1'b0;
      ck_prev_reg <= 1'b0;
    end else begin
      ck_meta_reg <= sclk;
      ck_sync_reg <= ck_meta_reg;
      ck_prev_reg <= ck_sync_reg;
    end
  end
  assign cs_fall = cs_prev_reg & ~cs_sync_reg;
  assign cs_rise = ~cs_prev_reg & cs_sync_reg;
  assign frame_on = ~cs_sync_reg;
  // Clock edges count only inside a frame
  assign ck_fall = frame_on & ~cs_fall & ck_prev_reg & ~ck_sync_reg;
  assign ck_rise = frame_on & ~cs_fall & ~ck_prev_reg & ck_sync_reg;
  // Difference of the separately held inputs, two guard bits against overflow
  assign diff_w = {{2{hold_pos_reg[AW-1]}}, hold_pos_reg} -
                  {{2{hold_neg_reg[AW-1]}}, hold_neg_reg};
  assign ref_w = {{2{hold_ref_reg[AW-1]}}, hold_ref_reg};
  sar_quantizer #(
    .WIDTH(AW)
  ) u_quant (
    .diff_in(diff_w),
    .ref_in(ref_w),
    .code(quant_full)
  );
  // Keep the top WIDTH bits of the wide quantizer: same step of 2*ref/2^WIDTH
  assign code = quant_full[AW-1:AW-WIDTH];
  always @* begin
    state_next = state;
    case (state)
      `STATE_ACQUIRE: begin
        if (cs_fall) begin
          state_next = `STATE_CONVERT;
        end
      end
      `STATE_CONVERT: begin
        // The 18th fall ends conversion; the power-up frame goes on to calibrate
        if (ck_fall && fall_cnt_reg == `CONV_EDGES - 7'd1) begin
          state_next = first_frame_reg ? `STATE_OFFSET_CAL : `STATE_ACQUIRE;
        end else if (cs_rise) begin
          state_next = `STATE_ACQUIRE;
        end
      end
      `STATE_OFFSET_CAL: begin
        // Early rise of select aborts calibration
        if (cs_rise) begin
          state_next = `STATE_ACQUIRE;
        end else if (ck_fall && fall_cnt_reg == `CAL_EDGES_POWERUP - 7'd1) begin
          state_next = `STATE_ACQUIRE;
        end
      end
      default: begin
        // Unused code recovers to a safe state
        state_next = `STATE_ACQUIRE;
      end
    endcase
  end
  // Control state and its decoded outputs
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= `STATE_ACQUIRE;
      sampling_closed <= 1'b1;
      cal_done <= 1'b0;
    end else begin
      state <= state_next;
      // Registered from the next state so it never lags the state itself
      sampling_closed <= (state_next == `STATE_ACQUIRE);
      cal_done <= 1'b0;
      // Pulse only when the 24th fall lands inside the frame
      if (ck_fall && state == `STATE_OFFSET_CAL &&
          fall_cnt_reg == `CAL_EDGES_POWERUP - 7'd1) begin
        cal_done <= 1'b1;
      end
    end
  end
  // Capture, shift and result path
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_pos_reg <= {AW{1'b0}};
      hold_neg_reg <= {AW{1'b0}};
      hold_ref_reg <= {AW{1'b0}};
      result_reg <= `MID_CODE;
      shift_reg <= `MID_CODE;
      fall_cnt_reg <= 7'd0;
      first_frame_reg <= 1'b1;
      short_frame_reg <= 1'b0;
      frame_invalid_reg <= 1'b0;
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
      result_valid <= 1'b0;
    end else begin
      // Pin is released as soon as the synced select goes high
      sdo_oe <= frame_on & ~cs_rise;
      if (cs_fall) begin
        fall_cnt_reg <= 7'd0;
        sdo_out <= 1'b0;
        shift_reg <= result_reg;
        result_valid <= ~frame_invalid_reg & ~first_frame_reg;
        if (state == `STATE_ACQUIRE) begin
          hold_pos_reg <= pos_analog_in;
          hold_neg_reg <= neg_analog_in;
          hold_ref_reg <= analog_supply;
          short_frame_reg <= 1'b1;
        end
      end
      // Counter saturates, so a long frame cannot wrap into a false 18th edge
      if (ck_fall && fall_cnt_reg != 7'h7F) begin
        fall_cnt_reg <= fall_cnt_reg + 7'd1;
      end
      if (ck_rise && fall_cnt_reg != 7'd0) begin
        // Shift holds MSB first, zeros fill behind
        sdo_out <= shift_reg[WIDTH-1];
        shift_reg <= {shift_reg[WIDTH-2:0], 1'b0};
      end
      if (state == `STATE_CONVERT && ck_fall && fall_cnt_reg == `CONV_EDGES - 7'd1) begin
        result_reg <= first_frame_reg ? `MID_CODE : code;
        short_frame_reg <= 1'b0;
        frame_invalid_reg <= 1'b0;
      end
      // Frame end: power-up window closes whatever the clock count
      if (cs_rise) begin
        first_frame_reg <= 1'b0;
        if (state == `STATE_CONVERT && short_frame_reg) begin
          // Too few clocks: next frame carries an unfinished code
          frame_invalid_reg <= 1'b1;
          result_reg <= code ^ {WIDTH{1'b1}};
          short_frame_reg <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** testbench/host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic cal_done,
  input wire logic result_valid,
  output logic cs_n,
  output logic sclk,
  output logic [13:0] word,
  output logic valid_seen,
  output logic cal_seen
);
  logic last;
  // Released pin shows the inverse of its last value, never a lucky match
  wire logic sdo_pin = sdo_oe ? sdo_out : ~last;
  initial begin
    cs_n = 1;
    sclk = 0;
    last = 0;
    word = 0;
    valid_seen = 0;
    cal_seen = 0;
  end
  always @(negedge sdo_oe) last = sdo_out;
  always @(posedge cal_done) cal_seen = 1;
  task automatic frame(input int falls);
    cs_n <= 0;
    #100;
    for (int k = 1; k <= falls; k++) begin
      sclk <= 1;
      #62.5 sclk <= 0;
      if (k >= 2 && k <= 15) word = {word[12:0], sdo_pin};
      #62.5;
    end
    valid_seen = result_valid;
    cs_n <= 1;
    #300;
  endtask
  task automatic stray();
    repeat (8) #62.5 sclk <= ~sclk;
  endtask
endmodule
`default_nettype wire

// *** testbench/sar_adc_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "sar_adc_map.vh"
module sar_adc_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic sampling_closed,
  input wire logic [1:0] state,
  input wire logic cal_done
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_float_idle: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("data pin driven while deselected");
  a_acq_closed: assert property (state == `STATE_ACQUIRE |-> sampling_closed)
    else $error("switches open in acquire");
  a_state_legal: assert property (state != 2'b11)
    else $error("illegal state");
  a_cs_start: assert property ($fell(cs_n) && state == `STATE_ACQUIRE |->
    ##[1:5] state == `STATE_CONVERT) else $error("no convert after select");
  a_cal_back: assert property (cal_done |-> ##[0:3] state == `STATE_ACQUIRE)
    else $error("no return to acquire after calibration");
  a_oe_rise: assert property ($fell(cs_n) |-> ##[2:5] sdo_oe)
    else $error("data pin not enabled in frame");
  a_lead_zero: assert property ($rose(sdo_oe) |-> !sdo_out)
    else $error("no leading zero");
  a_idle_sclk: assert property (cs_n [*6] |-> $stable(state) && $stable(sdo_out))
    else $error("serial clock acted while deselected");
  a_sdo_hold: assert property ((!sclk && !cs_n) [*6] |-> $stable(sdo_out))
    else $error("data moved without a clock rise");
  c_cal: cover property (cal_done);
  c_frame: cover property ($rose(sdo_oe));
  c_conv: cover property (state == `STATE_CONVERT ##1 state == `STATE_ACQUIRE);
endmodule
bind sar_adc_serial_frame_control sar_adc_properties chk (.mclk(mclk), .rst(rst),
  .cs_n(cs_n), .sclk(sclk), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
  .sampling_closed(sampling_closed), .state(state), .cal_done(cal_done));
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk, rst;
  logic signed [15:0] pos_in, neg_in, ref_v;
  wire logic cs_n, sclk, sdo_out, sdo_oe, closed, cal_done, valid, valid_seen, cal_seen;
  wire logic [1:0] state;
  wire logic [13:0] word;
  int mismatches, checks, cycles;
  typedef struct {logic [15:0] p; logic [15:0] n; logic [13:0] code;} row_t;
  // Reference 4000 hex makes one step two input units
  row_t rows [6] = '{'{16'h0000, 16'h0000, 14'h0000}, '{16'h0002, 16'h0000, 14'h0001},
    '{16'h7FFF, 16'h8000, 14'h1FFF}, '{16'h8000, 16'h7FFF, 14'h2000},
    '{16'h0100, 16'h0000, 14'h0080}, '{16'h0000, 16'h0100, 14'h3F80}};
  sar_adc_serial_frame_control DUT (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sclk(sclk),
    .pos_analog_in(pos_in), .neg_analog_in(neg_in), .analog_supply(ref_v),
    .sdo_out(sdo_out), .sdo_oe(sdo_oe), .sampling_closed(closed), .state(state),
    .cal_done(cal_done), .result_valid(valid));
  host_model host (.sdo_out(sdo_out), .sdo_oe(sdo_oe), .cal_done(cal_done),
    .result_valid(valid), .cs_n(cs_n), .sclk(sclk), .word(word),
    .valid_seen(valid_seen), .cal_seen(cal_seen));
  task automatic check(input string name, input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    mclk = 0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      summarize();
    end
  end
  initial begin
    rst = 1;
    pos_in = 0;
    neg_in = 0;
    ref_v = 16'h4000;
    repeat (16) @(posedge mclk);
    rst <= 0;
    repeat (4) @(posedge mclk);
    check("state", state, 2'b00);
    check("closed", closed, 1'b1);
    check("oe", sdo_oe, 1'b0);
    host.frame(24);
    check("first_word", word, 14'h0000);
    check("cal_done", cal_seen, 1'b1);
    check("state", state, 2'b00);
    $display("test power-up done");
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      pos_in <= rows[i % 6].p;
      neg_in <= rows[i % 6].n;
      @(posedge mclk);
      host.frame(18);
      if (i > 0) check("code", word, rows[i-1].code);
      if (i > 0) check("valid", valid_seen, 1'b1);
    end
    $display("test codes done");
    host.frame(10);
    check("state", state, 2'b00);
    pos_in <= 16'h0100;
    neg_in <= 16'h0000;
    host.frame(18);
    check("valid", valid_seen, 1'b0);
    host.stray();
    check("state", state, 2'b00);
    check("oe", sdo_oe, 1'b0);
    host.frame(18);
    check("code", word, 14'h0080);
    check("valid", valid_seen, 1'b1);
    $display("test short frame done");
    rst <= 1;
    repeat (16) @(posedge mclk);
    rst <= 0;
    repeat (4) @(posedge mclk);
    check("state", state, 2'b00);
    check("oe", sdo_oe, 1'b0);
    host.frame(18);
    check("first_word", word, 14'h0000);
    check("valid", valid_seen, 1'b0);
    check("state", state, 2'b00);
    $display("test reset again done");
    summarize();
  end
endmodule
`default_nettype wire
